// ### design/psq_pkg.sv
package psq_pkg;

    //////////////////////////////////////////////////////////////////////////
    // Clock and oscillator timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 5000;
    localparam int DISCHARGE_NS  = 95;
    // Least time, so rounded up to whole clocks
    localparam int DISCH_CYC     = (DISCHARGE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int OSC_CYC       = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CHARGE_CYC    = OSC_CYC - DISCH_CYC;
    localparam int POS_W         = 12;

    //////////////////////////////////////////////////////////////////////////
    // Recovery sequence, in oscillator cycles
    localparam int RETRY_WAIT_CYC = 56;
    localparam int SYNC_LEAD_CYC  = 1;
    localparam int SOFT_RAMP_CYC  = 5;
    localparam int START_MIN_CYC  = 57;
    localparam int START_MAX_CYC  = 62;
    localparam int SOFT_MIN_CYC   = 4;
    localparam int SOFT_MAX_CYC   = 7;
    localparam int RECOVERY_CYC   = 64;
    localparam int CNT_W          = 8;

    //////////////////////////////////////////////////////////////////////////
    // Sequencer states
    typedef enum logic [4:0] {
        ST_LOCK = 5'h01,
        ST_WAIT = 5'h02,
        ST_SYNC = 5'h04,
        ST_SOFT = 5'h08,
        ST_RUN  = 5'h10
    } psq_state_t;

endpackage

// ### design/psq_osc_if.sv
`timescale 1ns/10ps
`default_nettype none

interface psq_osc_if;
    import psq_pkg::*;

    logic             osc_run;
    logic             discharge;
    logic             cycle_start;
    logic [POS_W-1:0] charge_pos;

    modport osc (
        input  osc_run,
        output discharge,
        output cycle_start,
        output charge_pos
    );

    modport seq (
        output osc_run,
        input  discharge,
        input  cycle_start,
        input  charge_pos
    );
endinterface

`default_nettype wire

// ### design/psq_osc.sv
`timescale 1ns/10ps
`default_nettype none

module psq_osc
    import psq_pkg::*;
#(
    parameter int CHARGE_LEN = CHARGE_CYC,
    parameter int DISCH_LEN  = DISCH_CYC
) (
    input  wire logic clock_i,
    input  wire logic resetn_i,
    psq_osc_if.osc    osc
);

    typedef struct packed {
        logic [POS_W-1:0] cnt;
        logic             dis;
        logic             start;
    } psq_osc_st_t;

    localparam logic [POS_W-1:0] CHARGE_LAST = POS_W'(CHARGE_LEN - 1);
    localparam logic [POS_W-1:0] DISCH_LAST  = POS_W'(DISCH_LEN - 1);
    localparam int               DIS_HOLD    = DISCH_LEN;

    psq_osc_st_t st_reg;
    psq_osc_st_t st_next;

    //////////////////////////////////////////////////////////////////////////
    // Charge ramp then discharge; held at the ramp start while stopped
    always_comb begin
        st_next       = st_reg;
        st_next.start = 1'b0;
        if (!osc.osc_run) begin
            st_next.cnt = '0;
            st_next.dis = 1'b0;
        end else if (!st_reg.dis) begin
            if (st_reg.cnt == CHARGE_LAST) begin
                st_next.cnt   = '0;
                st_next.dis   = 1'b1;
                st_next.start = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end else if (st_reg.cnt == DISCH_LAST) begin
            st_next.cnt = '0;
            st_next.dis = 1'b0;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Position frozen at the top during discharge
    assign osc.discharge   = st_reg.dis;
    assign osc.cycle_start = st_reg.start;
    assign osc.charge_pos  = st_reg.dis ? CHARGE_LAST : st_reg.cnt;

    //////////////////////////////////////////////////////////////////////////
    AST_OSC_DIS_LEN: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        $rose(osc.discharge) |->
            ##[DIS_HOLD:DIS_HOLD] (!osc.discharge || !osc.osc_run))
        else $error("discharge interval has wrong length");

    AST_OSC_START: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        osc.cycle_start |-> $rose(osc.discharge))
        else $error("cycle start not aligned to discharge");

endmodule // psq_osc

`default_nettype wire

// ### design/psq_seq.sv
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Sync is low in lockout and in the retry wait after a fault; it pulses in ST_SYNC before the drives start.
// - While running, sync is high for each oscillator discharge, one clock late and of the same width.
// - After its first clock, the sync pulse lies in the dead time where no drive output is high.
// - Outside a fault or lockout, a drive falls only after sync has risen and rises only after it fell.
// - Drive pulses alternate strictly between the two outputs.
// - Each drive output runs at half the oscillator rate.
// - Over-current starts a shutdown that turns both drives off at once.
// - After a fault at least 56 oscillator cycles pass before retrying.
// - The first drive pulse comes 57 to 62 oscillator cycles into the delay.
// - Soft start takes 4 to 7 oscillator cycles up to the first full pulse.
// - Soft start delays each pulse start, the delay shrinking every cycle.
// - Recovery takes 62 cycles, within 64: quiet wait, sync pulses, then the ramp.
// - Sync pulses at least one oscillator cycle before the first drive.
// - A toggle latch forces alternation even at very low duty ratio.
module psq_seq
    import psq_pkg::*;
#(
    parameter int WAIT_CYCLES = RETRY_WAIT_CYC,
    parameter int SYNC_CYCLES = SYNC_LEAD_CYC,
    parameter int SOFT_CYCLES = SOFT_RAMP_CYC,
    parameter int CHARGE_LEN  = CHARGE_CYC,
    parameter int DISCH_LEN   = DISCH_CYC
) (
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic supply_low_lockout_i,
    input  wire logic over_current_i,
    output logic      drive_phase_one_o,
    output logic      drive_phase_two_o,
    output logic      sync_o,
    output logic      restart_hold_o
);

    typedef struct packed {
        psq_state_t       state;
        logic [CNT_W-1:0] cyc_cnt;
        logic [POS_W-1:0] lead;
        logic             phase_two;
        logic             drive_one;
        logic             drive_two;
        logic             sync;
        logic             hold;
        logic [CNT_W-1:0] since_flt;
        logic             first_pend;
        logic [1:0]       nsync;
        logic [1:0]       last_ph;
        logic [1:0]       gap_one;
        logic             seen_one;
        logic [POS_W-1:0] sync_len;
        logic [3:0]       soft_len;
    } psq_seq_st_t;

    localparam logic [CNT_W-1:0] WAIT_LAST  = CNT_W'(WAIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] SYNC_LAST  = CNT_W'(SYNC_CYCLES - 1);
    localparam logic [CNT_W-1:0] SOFT_LAST  = CNT_W'(SOFT_CYCLES - 1);
    localparam int               STEP_INT   = CHARGE_LEN / (SOFT_CYCLES + 1);
    localparam logic [POS_W-1:0] LEAD_STEP  = POS_W'(STEP_INT);
    localparam logic [POS_W-1:0] LEAD_START = POS_W'(STEP_INT * SOFT_CYCLES);
    localparam logic [POS_W-1:0] DIS_HI     = POS_W'(DISCH_LEN);
    localparam psq_seq_st_t      SEQ_RESET  = '{
        state:      ST_LOCK,
        first_pend: 1'b1,
        default:    '0
    };

    psq_seq_st_t r;
    psq_seq_st_t n;
    logic        flt_evt;
    logic        base_on;
    logic        rise_ok;
    logic        up_one;
    logic        up_two;

    psq_osc_if osc_bus ();

    psq_osc #(
        .CHARGE_LEN (CHARGE_LEN),
        .DISCH_LEN  (DISCH_LEN)
    ) u_osc (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .osc      (osc_bus)
    );

    //////////////////////////////////////////////////////////////////////////
    // State decoding
    function automatic logic is_active(input psq_state_t s);
        is_active = (s == ST_SYNC) || (s == ST_SOFT) || (s == ST_RUN);
    endfunction

    function automatic logic is_driving(input psq_state_t s);
        is_driving = (s == ST_SOFT) || (s == ST_RUN);
    endfunction

    // Oscillator is stopped in lockout so the delay starts from a clean ramp
    assign osc_bus.osc_run = (r.state != ST_LOCK);

    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        n       = r;
        flt_evt = over_current_i || supply_low_lockout_i;
        unique case (r.state)
            ST_LOCK: begin
                n.cyc_cnt = '0;
                if (!supply_low_lockout_i) begin
                    n.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (over_current_i) begin
                    n.cyc_cnt = '0;
                end else if (osc_bus.cycle_start) begin
                    if (r.cyc_cnt == WAIT_LAST) begin
                        n.state   = ST_SYNC;
                        n.cyc_cnt = '0;
                    end else begin
                        n.cyc_cnt = r.cyc_cnt + 1'b1;
                    end
                end
            end
            ST_SYNC: begin
                if (osc_bus.cycle_start) begin
                    if (r.cyc_cnt == SYNC_LAST) begin
                        n.state   = ST_SOFT;
                        n.cyc_cnt = '0;
                        n.lead    = LEAD_START;
                    end else begin
                        n.cyc_cnt = r.cyc_cnt + 1'b1;
                    end
                end
            end
            ST_SOFT: begin
                if (osc_bus.cycle_start) begin
                    if (r.cyc_cnt == SOFT_LAST) begin
                        n.state = ST_RUN;
                        n.lead  = '0;
                    end else begin
                        n.cyc_cnt = r.cyc_cnt + 1'b1;
                        n.lead    = r.lead - LEAD_STEP;
                    end
                end
            end
            ST_RUN: begin
                n.lead = '0;
            end
            // Only a corrupted code lands here; restart cleanly
            default: begin
                n.state = ST_LOCK;
            end
        endcase

        if (over_current_i && is_active(r.state)) begin
            n.state   = ST_WAIT;
            n.cyc_cnt = '0;
        end
        if (supply_low_lockout_i) begin
            n.state = ST_LOCK;
        end
        n.hold = (n.state == ST_WAIT) || (n.state == ST_LOCK);

        // Sync copies discharge one clock late, same width
        n.sync = osc_bus.discharge && is_active(n.state);

        // Drives release one clock after sync rises, start after it falls
        base_on = is_driving(n.state) && !r.sync;
        rise_ok = !osc_bus.discharge && (osc_bus.charge_pos >= r.lead);
        n.drive_one = base_on && !r.phase_two && (rise_ok || r.drive_one);
        n.drive_two = base_on && r.phase_two && (rise_ok || r.drive_two);
        // Toggle on pulse end, so a skipped cycle cannot repeat a phase
        if ((r.drive_one && !n.drive_one) || (r.drive_two && !n.drive_two)) begin
            n.phase_two = !r.phase_two;
        end

        // Observation fields
        up_one = n.drive_one && !r.drive_one;
        up_two = n.drive_two && !r.drive_two;
        if (flt_evt) begin
            n.since_flt  = '0;
            n.first_pend = 1'b1;
            n.nsync      = '0;
            n.seen_one   = 1'b0;
        end else begin
            if (osc_bus.cycle_start && (r.since_flt != '1)) begin
                n.since_flt = r.since_flt + 1'b1;
            end
            if (n.sync && !r.sync && (r.nsync != 2'h3)) begin
                n.nsync = r.nsync + 1'b1;
            end
            if (up_one || up_two) begin
                n.first_pend = 1'b0;
            end
            if (up_one) begin
                n.seen_one = 1'b1;
            end
        end
        if (up_one) begin
            n.last_ph = 2'h1;
            n.gap_one = '0;
        end else if (up_two) begin
            n.last_ph = 2'h2;
        end
        if (!up_one && osc_bus.cycle_start && (r.gap_one != 2'h3)) begin
            n.gap_one = r.gap_one + 1'b1;
        end
        if (n.sync) begin
            n.sync_len = r.sync ? r.sync_len + 1'b1 : POS_W'(1);
        end
        if (r.state != ST_SOFT) begin
            n.soft_len = '0;
        end
        if ((r.state == ST_SOFT) && osc_bus.cycle_start) begin
            n.soft_len = r.soft_len + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= SEQ_RESET;
        end else begin
            r <= n;
        end
    end

    assign drive_phase_one_o = r.drive_one;
    assign drive_phase_two_o = r.drive_two;
    assign sync_o            = r.sync;
    assign restart_hold_o    = r.hold;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_sync_up;
        $rose(r.sync);
    endsequence

    sequence s_drive_up;
        $rose(r.drive_one) || $rose(r.drive_two);
    endsequence

    sequence s_drive_down;
        $fell(r.drive_one) || $fell(r.drive_two);
    endsequence

    AST_SYNC_QUIET: assert property (
        (r.state == ST_LOCK) || (r.state == ST_WAIT) |-> !r.sync)
        else $error("sync high while outputs are shut down");

    AST_SYNC_WIDTH: assert property (
        $fell(r.sync) && is_active(r.state) |-> r.sync_len == DIS_HI)
        else $error("sync pulse width differs from discharge time");

    AST_SYNC_DEAD: assert property (
        r.sync && $past(r.sync) |-> !r.drive_one && !r.drive_two)
        else $error("drive high inside the dead time");

    AST_FALL_AFTER_SYNC: assert property (
        s_drive_down ##0 is_driving(r.state) |-> $past(r.sync))
        else $error("drive fell before sync rose");

    AST_RISE_AFTER_SYNC: assert property (
        s_drive_up |-> !r.sync && !$past(r.sync) && !$past(osc_bus.discharge))
        else $error("drive rose before sync fell");

    AST_ALTERNATE: assert property (
        ($rose(r.drive_one) |-> $past(r.last_ph) != 2'h1) and
        ($rose(r.drive_two) |-> $past(r.last_ph) != 2'h2))
        else $error("same drive output pulsed twice in a row");

    AST_HALF_RATE: assert property (
        $rose(r.drive_one) && $past(r.seen_one) && (r.state == ST_RUN)
            |-> $past(r.gap_one) == 2'h2)
        else $error("drive output not at half oscillator rate");

    AST_OC_OFF: assert property (
        over_current_i && !supply_low_lockout_i && is_active(r.state)
            |=> !r.drive_one && !r.drive_two && !r.sync
                && (r.state == ST_WAIT) && r.hold)
        else $error("over-current did not shut the outputs");

    AST_RETRY_WAIT: assert property (
        s_sync_up ##0 r.first_pend |-> r.since_flt >= CNT_W'(WAIT_CYCLES))
        else $error("retry before the hold-off elapsed");

    AST_FIRST_DRIVE: assert property (
        s_drive_up ##0 $past(r.first_pend) |=>
            r.since_flt >= CNT_W'(START_MIN_CYC)
            && r.since_flt <= CNT_W'(START_MAX_CYC))
        else $error("first drive pulse outside its start window");

    AST_SOFT_LEN: assert property (
        $rose(r.state == ST_RUN) |->
            r.soft_len >= 4'(SOFT_MIN_CYC) && r.soft_len <= 4'(SOFT_MAX_CYC))
        else $error("soft start length out of range");

    AST_LEAD_SHRINK: assert property (
        (r.state == ST_SOFT) && osc_bus.cycle_start && !flt_evt
            |=> r.lead < $past(r.lead))
        else $error("leading-edge delay did not shrink");

    AST_RECOVERY_SPAN: assert property (
        $rose(r.state == ST_RUN) |->
            r.since_flt <= CNT_W'(RECOVERY_CYC)
            && r.since_flt > CNT_W'(WAIT_CYCLES))
        else $error("recovery sequence exceeds its span");

    AST_SYNC_LEADS: assert property (
        s_drive_up ##0 $past(r.first_pend)
            |-> r.nsync >= 2'h1 && r.nsync <= 2'h2)
        else $error("no sync pulse ahead of the first drive");

    AST_LOCK_QUIET: assert property (
        supply_low_lockout_i |=>
            !r.drive_one && !r.drive_two && !r.sync && (r.state == ST_LOCK))
        else $error("outputs active during lockout");

endmodule // psq_seq

`default_nettype wire

// ### verif/psq_gate_model.sv
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Gate and secondary-side model: watches drives and sync, senses current
module psq_gate_model
    import psq_pkg::*;
#(
    parameter int DISCH_LEN = DISCH_CYC
) (
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic drive_one_i,
    input  wire logic drive_two_i,
    input  wire logic sync_i,
    input  wire logic trip_i,
    input  wire logic lockout_i,
    output logic      over_current_o
);
    int   alt_err;
    int   dead_err;
    int   fall_err;
    int   sync_err;
    int   pulse_cnt;
    int   width;
    int   swidth;
    int   widths [0:255];
    logic d_q;
    logic s_q;
    logic s_qq;
    logic last_two;
    logic excuse_q;
    logic d;
    logic excuse;

    assign d = drive_one_i | drive_two_i;
    // Cut pulses are expected around a fault or lockout
    assign excuse = trip_i | lockout_i | excuse_q;
    // Sense comparator follows the commanded trip without delay
    assign over_current_o = trip_i;

    //////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            d_q      <= 1'b0;
            s_q      <= 1'b0;
            s_qq     <= 1'b0;
            excuse_q <= 1'b0;
            swidth   <= 0;
            width    <= 0;
            last_two <= 1'b1;
        end else begin
            d_q      <= d;
            s_q      <= sync_i;
            s_qq     <= s_q;
            excuse_q <= trip_i | lockout_i;
            if (drive_one_i && drive_two_i)
                dead_err <= dead_err + 1;
            if (d && !d_q) begin
                if (s_q || sync_i)
                    dead_err <= dead_err + 1;
                if (drive_two_i == last_two)
                    alt_err <= alt_err + 1;
                last_two <= drive_two_i;
                width    <= 1;
            end else if (d) begin
                width <= width + 1;
            end
            if (!d && d_q) begin
                widths[pulse_cnt % 256] <= width;
                pulse_cnt <= pulse_cnt + 1;
                if (!excuse && !(s_q && !s_qq))
                    fall_err <= fall_err + 1;
            end
            swidth <= sync_i ? swidth + 1 : 0;
            if (!sync_i && s_q && !excuse && swidth != DISCH_LEN)
                sync_err <= sync_err + 1;
        end
    end
endmodule // psq_gate_model

`default_nettype wire

// ### verif/push_pull_fault_soft_start_seq_test.sv
`timescale 1ns/10ps
`default_nettype none

module push_pull_fault_soft_start_seq_test;
    import psq_pkg::*;

    // Short oscillator keeps the 62-cycle recoveries quick
    localparam int CH = 20;
    localparam int DC = 3;
    localparam int P  = CH + DC;

    logic clock;
    logic resetn;
    logic lockout;
    logic trip;
    logic d1;
    logic d2;
    logic sync;
    logic hold;
    logic oc;
    int   fails;
    int   n_compared;

    psq_seq #(.CHARGE_LEN(CH), .DISCH_LEN(DC)) dut (
        .clock_i              (clock),
        .resetn_i             (resetn),
        .supply_low_lockout_i (lockout),
        .over_current_i       (oc),
        .drive_phase_one_o    (d1),
        .drive_phase_two_o    (d2),
        .sync_o               (sync),
        .restart_hold_o       (hold)
    );

    psq_gate_model #(.DISCH_LEN(DC)) partner (
        .clock_i        (clock),
        .resetn_i       (resetn),
        .drive_one_i    (d1),
        .drive_two_i    (d2),
        .sync_i         (sync),
        .trip_i         (trip),
        .lockout_i      (lockout),
        .over_current_o (oc)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    //////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0:       return d1;
            1:       return d2;
            2:       return sync;
            default: return d1 | d2;
        endcase
    endfunction

    // Bounded wait on a level; a spent bound ends the run
    task automatic wait_lvl(input int sel, input logic val, input int lim,
                            output int n);
        n = 0;
        while (pick(sel) !== val) begin
            @(negedge clock);
            n++;
            if (n > lim) begin
                check(32'h0, 32'h1);
                results();
            end
        end
    endtask

    task automatic wait_cnt(input int target);
        int n;
        n = 0;
        while (partner.pulse_cnt < target) begin
            @(negedge clock);
            n++;
            if (n > 4 * P) begin
                check(32'h0, 32'h1);
                results();
            end
        end
    endtask

    task automatic quiet(input int cycles);
        repeat (cycles) begin
            @(negedge clock);
            check({d1, d2, sync, hold}, 4'h1);
        end
    endtask

    //////////////////////////////////////////////////////////////////////////
    // Pulses must widen until the first full one
    task automatic t_soft(input time t0);
        int i;
        int p0;
        int w;
        int prev;
        p0   = partner.pulse_cnt;
        prev = 0;
        for (i = 0; i < 9; i++) begin
            wait_cnt(p0 + i + 1);
            w = partner.widths[(p0 + i) % 256];
            if (w == CH)
                break;
            check(w > prev, 1'b1);
            prev = w;
        end
        check(i >= 4 && i <= 7, 1'b1);
        check(($time - t0) <= 65 * P * 10, 1'b1);
    endtask

    task automatic t_recover(input time t0);
        int n1;
        int n2;
        wait_lvl(2, 1'b1, 64 * P, n1);
        check(n1 >= 55 * P, 1'b1);
        wait_lvl(4, 1'b1, 8 * P, n2);
        check(n2 >= P, 1'b1);
        check(n1 + n2 >= 56 * P && n1 + n2 <= 63 * P, 1'b1);
        t_soft(t0);
    endtask

    task automatic t_startup;
        quiet(3 * P);
        lockout = 1'b0;
        t_recover($time);
    endtask

    task automatic t_run;
        int  n;
        time t1;
        // Entry may fall inside a sync pulse; align to a rising edge
        wait_lvl(2, 1'b0, 2 * P, n);
        wait_lvl(2, 1'b1, 2 * P, n);
        t1 = $time;
        wait_lvl(2, 1'b0, 2 * P, n);
        wait_lvl(2, 1'b1, 2 * P, n);
        check(32'(($time - t1) / 10), P);
        wait_lvl(0, 1'b1, 3 * P, n);
        wait_lvl(0, 1'b0, 3 * P, n);
        t1 = $time;
        wait_lvl(0, 1'b1, 3 * P, n);
        wait_lvl(0, 1'b0, 3 * P, n);
        check(32'(($time - t1) / 10), 2 * P);
        check(hold, 1'b0);
        check(partner.alt_err, 0);
        check(partner.dead_err, 0);
        check(partner.fall_err, 0);
        check(partner.sync_err, 0);
    endtask

    // Fault mid-pulse, then a second trip inside the hold-off
    task automatic t_fault;
        int n;
        wait_lvl(0, 1'b1, 3 * P, n);
        repeat (5) @(negedge clock);
        trip = 1'b1;
        @(negedge clock);
        check({d1, d2, sync}, 3'h0);
        quiet(3 * P);
        trip = 1'b0;
        quiet(30 * P);
        trip = 1'b1;
        quiet(2);
        trip = 1'b0;
        t_recover($time);
        check(partner.alt_err, 0);
    endtask

    task automatic t_lock_mid;
        int n;
        wait_lvl(4, 1'b1, 3 * P, n);
        lockout = 1'b1;
        quiet(2 * P);
        lockout = 1'b0;
        wait_lvl(4, 1'b1, 64 * P, n);
        check(n >= 56 * P, 1'b1);
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        fails      = 0;
        n_compared = 0;
        resetn     = 1'b0;
        lockout    = 1'b1;
        trip       = 1'b0;
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        t_startup();
        t_run();
        t_fault();
        t_run();
        t_lock_mid();
        results();
    end
endmodule // push_pull_fault_soft_start_seq_test

`default_nettype wire
